// file: core/lcd_memory_access_control.v
`timescale 1ns/1ps
`default_nettype none
`include "lcd_mac_defines.vh"

module lcd_memory_access_control (
	// Clock and reset
	input wire sys_clk,
	input wire rst,
	// CPU register port
	input wire register_select_line,
	input wire cpu_wr,
	input wire cpu_rd,
	input wire [7:0] cpu_wdata,
	output reg [7:0] cpu_rdata,
	output reg cpu_rdata_valid,
	// Control state
	output reg panel_on,
	output reg amp_enable,
	output reg write_only_advance,
	output reg step_column_first,
	output reg flash_enable,
	output reg module_sleep,
	output reg graphic_mode_sel,
	output reg [1:0] duty_code,
	// Drive controls
	output reg flash_active,
	output reg lcd_outputs_grounded,
	output reg amp_outputs_hiz,
	// Cursor
	output reg [2:0] column_addr,
	output reg [4:0] row_addr,
	// Display scan port
	input wire [2:0] scan_column,
	input wire [4:0] scan_row,
	output reg [7:0] scan_data
);

////////////////////////////////////////////////////////////////////////////////
// Reset images

localparam [7:0] CTRL_ONE_INIT = `RST_CTRL_ONE;
localparam [7:0] CTRL_TWO_INIT = `RST_CTRL_TWO;
localparam [7:0] CURSOR_INIT = `RST_CURSOR;

////////////////////////////////////////////////////////////////////////////////
// Access decode

reg [3:0] index_pointer;
wire index_wr;
wire reg_wr;
wire reg_rd;
wire ctrl_one_wr;
wire ctrl_two_wr;
wire cursor_wr;
wire data_wr;
wire data_rd;
wire sleep_request;

assign index_wr = cpu_wr & ~register_select_line; // [R20]
assign reg_wr = cpu_wr & register_select_line;
assign reg_rd = cpu_rd & register_select_line;
assign ctrl_one_wr = reg_wr & (index_pointer == `IDX_CTRL_ONE); // [R20]
assign ctrl_two_wr = reg_wr & (index_pointer == `IDX_CTRL_TWO); // [R20]
assign cursor_wr = reg_wr & (index_pointer == `IDX_CURSOR); // [R20]
assign data_wr = reg_wr & (index_pointer == `IDX_DATA_PORT);
assign data_rd = reg_rd & (index_pointer == `IDX_DATA_PORT);
// A standing 1 in sleep clears nothing; only its write does
assign sleep_request = ctrl_one_wr & cpu_wdata[`C1_SLEEP_BIT];

////////////////////////////////////////////////////////////////////////////////
// Index pointer

always @(posedge sys_clk or posedge rst) begin
	if (rst) begin
		index_pointer <= `RST_INDEX;
	end else if (index_wr) begin
		index_pointer <= cpu_wdata[3:0]; // [R20]
	end
end

////////////////////////////////////////////////////////////////////////////////
// Control one fields used here

reg [7:0] next_ctrl_one;

always @* begin
	next_ctrl_one = cpu_wdata & `C1_WRITE_MASK;
end

always @(posedge sys_clk or posedge rst) begin
	if (rst) begin
		module_sleep <= CTRL_ONE_INIT[`C1_SLEEP_BIT];
	end else if (ctrl_one_wr) begin
		module_sleep <= next_ctrl_one[`C1_SLEEP_BIT];
	end
end

always @(posedge sys_clk or posedge rst) begin
	if (rst) begin
		graphic_mode_sel <= CTRL_ONE_INIT[`C1_GRAPHIC_BIT];
	end else if (ctrl_one_wr) begin
		graphic_mode_sel <= next_ctrl_one[`C1_GRAPHIC_BIT]; // [R23]
	end
end

always @(posedge sys_clk or posedge rst) begin
	if (rst) begin
		duty_code <= CTRL_ONE_INIT[`C1_DUTY_HI:`C1_DUTY_LO];
	end else if (ctrl_one_wr) begin
		duty_code <= next_ctrl_one[`C1_DUTY_HI:`C1_DUTY_LO]; // [R22]
	end
end

////////////////////////////////////////////////////////////////////////////////
// Control two

reg [7:0] wr_ctrl_two;
reg next_panel_on;
reg next_amp_enable;
reg next_write_only_advance;
reg next_step_column_first;
reg next_flash_enable;

always @* begin
	// Reserved bits never stored
	wr_ctrl_two = cpu_wdata & `C2_WRITE_MASK; // [R19]
	next_panel_on = panel_on;
	next_amp_enable = amp_enable;
	next_write_only_advance = write_only_advance;
	next_step_column_first = step_column_first;
	next_flash_enable = flash_enable;
	if (ctrl_two_wr) begin // [R1]
		next_panel_on = wr_ctrl_two[`C2_PANEL_BIT];
		next_amp_enable = wr_ctrl_two[`C2_AMP_BIT];
		next_write_only_advance = wr_ctrl_two[`C2_ADVANCE_BIT];
		next_step_column_first = wr_ctrl_two[`C2_AXIS_BIT];
		next_flash_enable = wr_ctrl_two[`C2_FLASH_BIT];
	end
	if (sleep_request) begin
		next_panel_on = 1'b0; // [R3]
		next_amp_enable = 1'b0; // [R4]
	end
end

////////////////////////////////////////////////////////////////////////////////
// Control two flops

always @(posedge sys_clk or posedge rst) begin
	if (rst) begin
		panel_on <= CTRL_TWO_INIT[`C2_PANEL_BIT]; // [R1]
	end else begin
		panel_on <= next_panel_on;
	end
end

always @(posedge sys_clk or posedge rst) begin
	if (rst) begin
		amp_enable <= CTRL_TWO_INIT[`C2_AMP_BIT];
	end else begin
		amp_enable <= next_amp_enable;
	end
end

always @(posedge sys_clk or posedge rst) begin
	if (rst) begin
		write_only_advance <= CTRL_TWO_INIT[`C2_ADVANCE_BIT];
	end else begin
		write_only_advance <= next_write_only_advance;
	end
end

always @(posedge sys_clk or posedge rst) begin
	if (rst) begin
		step_column_first <= CTRL_TWO_INIT[`C2_AXIS_BIT];
	end else begin
		step_column_first <= next_step_column_first;
	end
end

always @(posedge sys_clk or posedge rst) begin
	if (rst) begin
		flash_enable <= CTRL_TWO_INIT[`C2_FLASH_BIT];
	end else begin
		flash_enable <= next_flash_enable;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Drive controls, registered from the next values

always @(posedge sys_clk or posedge rst) begin
	if (rst) begin
		lcd_outputs_grounded <= ~CTRL_TWO_INIT[`C2_PANEL_BIT];
	end else begin
		lcd_outputs_grounded <= ~next_panel_on; // [R2]
	end
end

always @(posedge sys_clk or posedge rst) begin
	if (rst) begin
		amp_outputs_hiz <= ~CTRL_TWO_INIT[`C2_AMP_BIT];
	end else begin
		amp_outputs_hiz <= ~next_amp_enable; // [R5]
	end
end

always @(posedge sys_clk or posedge rst) begin
	if (rst) begin
		flash_active <= 1'b0;
	end else begin
		flash_active <= next_flash_enable & next_panel_on; // [R12]
	end
end

////////////////////////////////////////////////////////////////////////////////
// Cursor

wire [2:0] step_column;
wire [4:0] step_row;
wire advance;
reg [2:0] next_column_addr;
reg [4:0] next_row_addr;

// Reads step only outside write-only-advance mode
assign advance = data_wr | (data_rd & ~write_only_advance); // [R7] [R8]

cursor_stepper stepper (
	.column(column_addr),
	.row(row_addr),
	.step_column_first(step_column_first),
	.graphic_mode(graphic_mode_sel),
	.duty_code(duty_code),
	.next_column(step_column),
	.next_row(step_row)
);

always @* begin
	next_column_addr = column_addr;
	if (cursor_wr) begin // [R13]
		next_column_addr = cpu_wdata[`CUR_COL_HI:`CUR_COL_LO];
	end else if (advance) begin // [R7] [R8]
		next_column_addr = step_column; // [R9] [R10] [R11]
	end
end

always @* begin
	next_row_addr = row_addr;
	if (cursor_wr) begin // [R13]
		next_row_addr = cpu_wdata[`CUR_ROW_HI:`CUR_ROW_LO];
	end else if (advance) begin // [R7] [R8]
		next_row_addr = step_row;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Cursor flops

always @(posedge sys_clk or posedge rst) begin
	if (rst) begin
		column_addr <= CURSOR_INIT[`CUR_COL_HI:`CUR_COL_LO]; // [R13]
	end else begin
		column_addr <= next_column_addr;
	end
end

always @(posedge sys_clk or posedge rst) begin
	if (rst) begin
		row_addr <= CURSOR_INIT[`CUR_ROW_HI:`CUR_ROW_LO]; // [R13]
	end else begin
		row_addr <= next_row_addr;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Display memory

localparam MEM_DEPTH = 256;

reg [7:0] pixel_mem [0:MEM_DEPTH-1];
wire [7:0] cpu_mem_addr;
wire [7:0] scan_mem_addr;

assign cpu_mem_addr = {column_addr, row_addr}; // [R14]
assign scan_mem_addr = {scan_column, scan_row};

always @(posedge sys_clk) begin
	if (data_wr) begin
		pixel_mem[cpu_mem_addr] <= cpu_wdata; // [R21]
	end
end

////////////////////////////////////////////////////////////////////////////////
// Read latch

always @(posedge sys_clk or posedge rst) begin
	if (rst) begin
		cpu_rdata_valid <= 1'b0;
	end else begin
		cpu_rdata_valid <= data_rd; // [R21]
	end
end

// Holds the byte under the cursor before its step
always @(posedge sys_clk or posedge rst) begin
	if (rst) begin
		cpu_rdata <= 8'h00;
	end else if (data_rd) begin
		cpu_rdata <= pixel_mem[cpu_mem_addr]; // [R21] [R14]
	end
end

////////////////////////////////////////////////////////////////////////////////
// Scan output

localparam [7:0] CHAR_FIELD = `CHAR_MASK;

wire [7:0] scan_raw;
wire [7:0] scan_word;
genvar seg;

assign scan_raw = pixel_mem[scan_mem_addr];

// Upper bits drop out in character mode; all drop out with panel off
generate
	for (seg = 0; seg < 8; seg = seg + 1) begin : seg_gate
		wire keep_bit;
		assign keep_bit = graphic_mode_sel | CHAR_FIELD[seg]; // [R23]
		assign scan_word[seg] = panel_on & keep_bit & scan_raw[seg]; // [R2]
	end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Scan register

always @(posedge sys_clk or posedge rst) begin
	if (rst) begin
		scan_data <= 8'h00;
	end else begin
		scan_data <= scan_word;
	end
end

endmodule // lcd_memory_access_control
`default_nettype wire

// file: core/lcd_mac_defines.vh
// Behaviour
// R1 - Control two: 8-bit write-only, resets to zero
// R2 - Panel off grounds every LCD output
// R3 - Sleep write of 1 clears panel_on
// R4 - Sleep write of 1 clears amp_enable
// R5 - Amp enable 0 halts amps, outputs high-Z
// R6 - Software keeps amps off with external bias
// R7 - Advance 0: step after reads and writes
// R8 - Advance 1: step after writes only
// R9 - Axis 0: row first, column on overflow
// R10 - Axis 1: column first, row on overflow
// R11 - Priority axis wraps to zero, other steps
// R12 - Blink only with flash and panel on
// R13 - Cursor: 8-bit write-only, resets to zero
// R14 - Cursor gives data-port column and row
// R15 - Column limit depends on graphic duty
// R16 - Row limit depends on duty
// R17 - Axis 0 at row max: column increments
// R18 - Axis 1 at column max: row increments
// R19 - Software writes zero to reserved bits
// R20 - Select 0 loads index; index picks register
// R21 - Data port accesses memory; reads latched
// R22 - Duty code 00, 01, 1x: 1/32, 1/16, 1/8
// R23 - Character mode outputs five bits per byte
// R24 - Character mode: all columns valid
// R25 - Both axes at max: both wrap to zero
`ifndef LCD_MAC_DEFINES_VH
`define LCD_MAC_DEFINES_VH

// Index codes
`define IDX_CTRL_ONE 4'h0
`define IDX_CTRL_TWO 4'h1
`define IDX_CURSOR 4'h2
`define IDX_DATA_PORT 4'h4

// Reset values
`define RST_INDEX 4'h0
`define RST_CTRL_ONE 8'h00
`define RST_CTRL_TWO 8'h00
`define RST_CURSOR 8'h00

// Control one fields
`define C1_SLEEP_BIT 5
`define C1_GRAPHIC_BIT 2
`define C1_DUTY_HI 1
`define C1_DUTY_LO 0
`define C1_WRITE_MASK 8'h37

// Control two fields
`define C2_PANEL_BIT 6
`define C2_AMP_BIT 4
`define C2_ADVANCE_BIT 3
`define C2_AXIS_BIT 1
`define C2_FLASH_BIT 0
`define C2_WRITE_MASK 8'h5B

// Cursor fields
`define CUR_COL_HI 7
`define CUR_COL_LO 5
`define CUR_ROW_HI 4
`define CUR_ROW_LO 0

// Duty codes and limits
`define DUTY_32 2'h0
`define DUTY_16 2'h1
`define ROW_MAX_32 5'h1F
`define ROW_MAX_16 5'h0F
`define ROW_MAX_8 5'h07
`define COL_MAX_GFX_32 3'h4
`define COL_MAX_GFX_16 3'h6
`define COL_MAX_FULL 3'h7

// Character mode segment mask
`define CHAR_MASK 8'h1F

`endif

// file: core/cursor_stepper.v
`timescale 1ns/1ps
`default_nettype none
`include "lcd_mac_defines.vh"

module cursor_stepper (
	// Current cursor
	input wire [2:0] column,
	input wire [4:0] row,
	// Mode
	input wire step_column_first,
	input wire graphic_mode,
	input wire [1:0] duty_code,
	// Advanced cursor
	output reg [2:0] next_column,
	output reg [4:0] next_row
);

reg [2:0] col_max;
reg [4:0] row_max;
reg col_top;
reg row_top;

always @* begin
	case (duty_code) // [R22] [R16]
	`DUTY_32: row_max = `ROW_MAX_32;
	`DUTY_16: row_max = `ROW_MAX_16;
	default: row_max = `ROW_MAX_8;
	endcase
	if (!graphic_mode) begin
		col_max = `COL_MAX_FULL; // [R24]
	end else begin
		case (duty_code) // [R15]
		`DUTY_32: col_max = `COL_MAX_GFX_32;
		`DUTY_16: col_max = `COL_MAX_GFX_16;
		default: col_max = `COL_MAX_FULL;
		endcase
	end
	col_top = (column == col_max);
	row_top = (row == row_max);
	next_column = column;
	next_row = row;
	if (step_column_first) begin // [R10]
		if (col_top) begin
			next_column = 3'h0; // [R11]
			next_row = row_top ? 5'h00 : row + 5'h01; // [R18] [R25]
		end else begin
			next_column = column + 3'h1;
		end
	end else begin // [R9]
		if (row_top) begin
			next_row = 5'h00; // [R11]
			next_column = col_top ? 3'h0 : column + 3'h1; // [R17] [R25]
		end else begin
			next_row = row + 5'h01;
		end
	end
end

endmodule // cursor_stepper
`default_nettype wire

// file: bench/lcd_mac_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_mac_monitor (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// CPU port
	input wire logic register_select_line,
	input wire logic cpu_wr,
	input wire logic cpu_rd,
	input wire logic [7:0] cpu_wdata,
	input wire logic cpu_rdata_valid,
	// State and cursor
	input wire logic panel_on,
	input wire logic amp_enable,
	input wire logic write_only_advance,
	input wire logic flash_enable,
	input wire logic flash_active,
	input wire logic lcd_outputs_grounded,
	input wire logic amp_outputs_hiz,
	input wire logic [2:0] column_addr,
	input wire logic [4:0] row_addr,
	input wire logic [7:0] scan_data
);
	logic [3:0] idx;
	logic wr;
	logic rd4;
	// Shadow of the index pointer
	always_ff @(posedge sys_clk or posedge rst)
		if (rst) idx <= 4'h0;
		else if (cpu_wr && !register_select_line) idx <= cpu_wdata[3:0];
	assign wr = cpu_wr && register_select_line;
	assign rd4 = cpu_rd && register_select_line && idx == 4'h4;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	////////////////////////////////
	ground_follow_a: assert property (lcd_outputs_grounded == !panel_on)
		else $error("grounding differs from panel state");
	hiz_follow_a: assert property (amp_outputs_hiz == !amp_enable)
		else $error("amp high-z differs from amp enable");
	flash_gate_a: assert property (flash_active == (flash_enable && panel_on))
		else $error("flash active wrong");
	sleep_clear_a: assert property (wr && idx == 4'h0 && cpu_wdata[5] |=>
		!panel_on && !amp_enable) else $error("sleep did not clear panel and amps");
	ctrl_load_a: assert property (wr && idx == 4'h1 |=> panel_on == $past(cpu_wdata[6])
		&& amp_enable == $past(cpu_wdata[4])) else $error("control two not loaded");
	cursor_load_a: assert property (wr && idx == 4'h2 |=>
		{column_addr, row_addr} == $past(cpu_wdata)) else $error("cursor not loaded");
	write_step_a: assert property (wr && idx == 4'h4 |=>
		{column_addr, row_addr} != $past({column_addr, row_addr})) else $error("no step");
	read_hold_a: assert property (rd4 && write_only_advance |=>
		$stable({column_addr, row_addr})) else $error("cursor moved on rmw read");
	read_pulse_a: assert property (rd4 |=> cpu_rdata_valid)
		else $error("no read valid");
	no_pulse_a: assert property (!rd4 |=> !cpu_rdata_valid)
		else $error("stray read valid");
	dark_scan_a: assert property (!panel_on [*2] |=> scan_data == 8'h00)
		else $error("scan data while panel off");
	cover property (rd4 && write_only_advance);
	cover property (flash_active);
	cover property (wr && idx == 4'h0 && cpu_wdata[5]);
endmodule // lcd_mac_monitor
bind lcd_memory_access_control lcd_mac_monitor lcd_mac_monitor_i (.sys_clk, .rst,
	.register_select_line, .cpu_wr, .cpu_rd, .cpu_wdata, .cpu_rdata_valid, .panel_on,
	.amp_enable, .write_only_advance, .flash_enable, .flash_active, .lcd_outputs_grounded,
	.amp_outputs_hiz, .column_addr, .row_addr, .scan_data);
`default_nettype wire

// file: bench/cpu_port_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_port_model (
	// Clock
	input wire logic sys_clk,
	// Register port
	output logic register_select_line,
	output logic cpu_wr,
	output logic cpu_rd,
	output logic [7:0] cpu_wdata,
	input wire logic [7:0] cpu_rdata,
	input wire logic cpu_rdata_valid
);
	initial begin
		register_select_line = 1'b0;
		cpu_wr = 1'b0;
		cpu_rd = 1'b0;
		cpu_wdata = 8'h00;
	end
	// Released data bus shows the inverse
	task acc(input logic s, input logic [7:0] d);
		@(negedge sys_clk);
		register_select_line = s;
		cpu_wr = 1'b1;
		cpu_wdata = d;
		@(negedge sys_clk);
		cpu_wr = 1'b0;
		cpu_wdata = ~d;
	endtask
	task wreg(input logic [3:0] i, input logic [7:0] d);
		acc(1'b0, {4'h0, i});
		acc(1'b1, d);
	endtask
	task rreg(input logic [3:0] i, output logic [7:0] d, output logic v);
		acc(1'b0, {4'h0, i});
		@(negedge sys_clk);
		register_select_line = 1'b1;
		cpu_rd = 1'b1;
		@(negedge sys_clk);
		d = cpu_rdata;
		v = cpu_rdata_valid;
		cpu_rd = 1'b0;
	endtask
endmodule // cpu_port_model
`default_nettype wire

// file: bench/lcd_memory_access_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_memory_access_control_test;
	logic sys_clk = 1'b0;
	logic rst, register_select_line, cpu_wr, cpu_rd, cpu_rdata_valid, panel_on, amp_enable;
	logic write_only_advance, step_column_first, flash_enable, module_sleep, graphic_mode_sel;
	logic flash_active, lcd_outputs_grounded, amp_outputs_hiz;
	logic [7:0] cpu_wdata, cpu_rdata, scan_data;
	logic [1:0] duty_code;
	logic [2:0] column_addr, scan_column;
	logic [4:0] row_addr, scan_row;
	int err_count = 0;
	int num_checks = 0;
	always #2 sys_clk = ~sys_clk;
	lcd_memory_access_control lcd_memory_access_control_i (.sys_clk, .rst,
		.register_select_line, .cpu_wr, .cpu_rd, .cpu_wdata, .cpu_rdata, .cpu_rdata_valid,
		.panel_on, .amp_enable, .write_only_advance, .step_column_first, .flash_enable,
		.module_sleep, .graphic_mode_sel, .duty_code, .flash_active, .lcd_outputs_grounded,
		.amp_outputs_hiz, .column_addr, .row_addr, .scan_column, .scan_row, .scan_data);
	cpu_port_model cpu_port_model_i (.sys_clk, .register_select_line, .cpu_wr, .cpu_rd,
		.cpu_wdata, .cpu_rdata, .cpu_rdata_valid);
	////////////////////////////////
	task chk(input string n, input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", n, exp, got);
		end
	endtask
	task end_sim;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// Highest valid {column, row}
	function logic [7:0] mx(input logic g, input logic [1:0] d);
		return {(!g ? 3'h7 : d == 2'h0 ? 3'h4 : d == 2'h1 ? 3'h6 : 3'h7),
			(d == 2'h0 ? 5'h1F : d == 2'h1 ? 5'h0F : 5'h07)};
	endfunction
	function logic [7:0] nx(input logic [7:0] c, input logic ax, g, input logic [1:0] d);
		logic [7:0] m;
		logic top;
		m = mx(g, d);
		if (!ax) begin
			top = c[4:0] == m[4:0];
			c[4:0] = top ? 5'h00 : c[4:0] + 5'h01;
			if (top) c[7:5] = c[7:5] == m[7:5] ? 3'h0 : c[7:5] + 3'h1;
		end else begin
			top = c[7:5] == m[7:5];
			c[7:5] = top ? 3'h0 : c[7:5] + 3'h1;
			if (top) c[4:0] = c[4:0] == m[4:0] ? 5'h00 : c[4:0] + 5'h01;
		end
		return c;
	endfunction
	task t_reset;
		chk("control two", {3'h0, panel_on, amp_enable, write_only_advance,
			step_column_first, flash_enable}, 8'h00);
		chk("cursor", {column_addr, row_addr}, 8'h00);
		chk("drive", {6'h00, lcd_outputs_grounded, amp_outputs_hiz}, 8'h03);
		chk("control one", {4'h0, module_sleep, graphic_mode_sel, duty_code}, 8'h00);
		chk("idle", {6'h00, flash_active, cpu_rdata_valid}, 8'h00);
	endtask
	task t_step;
		logic [7:0] m, c;
		for (int k = 0; k < 16; k++) begin
			m = mx(k[1], k[3:2]);
			cpu_port_model_i.wreg(4'h0, {5'h00, k[1], k[3:2]});
			chk("control one", {5'h00, graphic_mode_sel, duty_code},
				{5'h00, k[1], k[3:2]});
			cpu_port_model_i.wreg(4'h1, {4'h0, k[0] ^ k[1], 1'b0, k[0], 1'b0});
			chk("control two", {3'h0, panel_on, amp_enable, write_only_advance,
				step_column_first, flash_enable}, {5'h00, k[0] ^ k[1], k[0], 1'b0});
			c = {m[7:5] - 3'h1, m[4:0] - 5'h01};
			cpu_port_model_i.wreg(4'h2, c);
			for (int j = 0; j < 3; j++) begin
				if (j == 2) c = m;
				if (j == 2) cpu_port_model_i.wreg(4'h2, c);
				cpu_port_model_i.wreg(4'h4, c);
				c = nx(c, k[0], k[1], k[3:2]);
				chk("step", {column_addr, row_addr}, c);
			end
		end
	endtask
	task t_read;
		logic [7:0] d;
		logic v;
		cpu_port_model_i.wreg(4'h0, 8'h04);
		cpu_port_model_i.wreg(4'h1, 8'h08);
		cpu_port_model_i.wreg(4'h2, 8'h41);
		cpu_port_model_i.wreg(4'h4, 8'hA5);
		cpu_port_model_i.wreg(4'h4, 8'h3C);
		cpu_port_model_i.wreg(4'h2, 8'h41);
		cpu_port_model_i.rreg(4'h4, d, v);
		chk("rmw data", d, 8'hA5);
		chk("rmw cursor", {column_addr, row_addr}, 8'h41);
		cpu_port_model_i.wreg(4'h1, 8'h00);
		cpu_port_model_i.rreg(4'h4, d, v);
		cpu_port_model_i.rreg(4'h4, d, v);
		chk("read data", d, 8'h3C);
		chk("read valid", {7'h00, v}, 8'h01);
		chk("read cursor", {column_addr, row_addr}, 8'h43);
		cpu_port_model_i.rreg(4'h2, d, v);
		chk("refused read", {7'h00, v}, 8'h00);
	endtask
	task t_scan;
		cpu_port_model_i.wreg(4'h1, 8'h51);
		scan_column = 3'h2;
		scan_row = 5'h02;
		chk("drive on", {3'h0, flash_active, lcd_outputs_grounded, amp_outputs_hiz,
			panel_on, amp_enable}, 8'h13);
		repeat (2) @(negedge sys_clk);
		chk("graphic scan", scan_data, 8'h3C);
		cpu_port_model_i.wreg(4'h0, 8'h00);
		repeat (2) @(negedge sys_clk);
		chk("char scan", scan_data, 8'h1C);
		cpu_port_model_i.wreg(4'h0, 8'h20);
		chk("sleep", {3'h0, flash_active, lcd_outputs_grounded, amp_outputs_hiz,
			panel_on, amp_enable}, 8'h0C);
		chk("sleep bit", {6'h00, module_sleep, flash_enable}, 8'h03);
		repeat (2) @(negedge sys_clk);
		chk("dark scan", scan_data, 8'h00);
	endtask
	task t_rerst;
		@(negedge sys_clk);
		rst = 1'b1;
		repeat (3) @(negedge sys_clk);
		rst = 1'b0;
		t_reset;
	endtask
	initial begin
		rst = 1'b1;
		scan_column = 3'h0;
		scan_row = 5'h00;
		repeat (20) @(negedge sys_clk);
		rst = 1'b0;
		t_reset;
		t_step;
		t_read;
		t_scan;
		t_rerst;
		end_sim;
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		err_count++;
		end_sim;
	end
endmodule // lcd_memory_access_control_test
`default_nettype wire
